//--- core/afx_execute.sv
// Execute stage: register file, word, multiply, jump, call, exit and skip
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module afx_execute (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             opValid,
  input  wire afx_pkg::afx_op_e opCode,
  input  wire logic [4:0]       dstSel,
  input  wire logic [4:0]       srcSel,
  input  wire logic [7:0]       immK,
  input  wire logic [2:0]       bitSel,
  input  wire logic [11:0]      relOffset,
  input  wire logic [15:0]      jumpTarget,
  input  wire logic             nextTwoWord,
  output logic                  opReady,
  output logic                  opDone,
  output logic [15:0]           pc,
  output logic [7:0]            flags,
  input  wire logic [5:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [7:0]            regRdata
);
  import afx_pkg::*;

  typedef struct packed {
    logic [31:0][7:0]  gpr;
    logic [7:0][15:0]  stack;
    logic [2:0]        sp;
    logic [15:0]       pc;
    logic [7:0]        flags;
    afx_state_e        st;
    logic [1:0]        left;
    logic              done;
    logic [7:0]        rdData;
  } afx_exec_s;

  localparam afx_exec_s RST_STATE = '{
    gpr: '0, stack: '0, sp: 3'h0, pc: RST_PC, flags: RST_FLAGS,
    st: ST_IDLE, left: 2'h0, done: 1'b0, rdData: 8'h00
  };

  afx_exec_s        s_q;
  afx_exec_s        s_d;
  logic             accept;
  logic [7:0]       aVal;
  logic [7:0]       bVal;
  logic [7:0]       aluB;
  logic [7:0]       aluRes;
  logic [7:0]       aluFlags;
  logic             aluWr;
  logic [4:0]       dstHi;
  logic [15:0]      pairVal;
  logic [15:0]      wordRes;
  logic [8:0]       mulA;
  logic [8:0]       mulB;
  logic [17:0]      product;
  logic [15:0]      mulRes;
  logic             isFrac;
  logic [15:0]      relTarget;
  logic [15:0]      ptrTarget;
  logic             skipTaken;
  logic [2:0]       cyc;
  logic [15:0]      nextPc;

  // Handshake: a new instruction is taken only while idle and enabled
  assign opReady = (s_q.st == ST_IDLE);
  assign accept = ce & opValid & opReady;
  assign opDone = s_q.done;
  assign pc = s_q.pc;
  assign flags = s_q.flags;
  assign regRdata = s_q.rdData;

  // Operand fetch; immediate forms take the constant as second operand
  assign aVal = s_q.gpr[dstSel];
  assign bVal = s_q.gpr[srcSel];
  always_comb begin
    unique case (opCode)
      OP_SUB_IMM, OP_SUB_IMM_BORROW, OP_AND_IMM, OP_OR_IMM, OP_SET_BITS,
      OP_CLEAR_BITS, OP_CMP_IMM: aluB = immK;
      OP_TEST, OP_ZERO_REG: aluB = aVal;
      default: aluB = bVal;
    endcase
  end

  afx_alu u_alu (
    .op       (opCode),
    .a        (aVal),
    .b        (aluB),
    .flagsIn  (s_q.flags),
    .res      (aluRes),
    .flagsOut (aluFlags),
    .wrRes    (aluWr)
  );

  // Word pair arithmetic on a low register and the one above it
  assign dstHi = dstSel + 5'h01;
  assign pairVal = {s_q.gpr[dstHi], aVal};
  assign wordRes = (opCode == OP_WORD_DIFF) ? pairVal - {10'h000, immK[5:0]}
                                            : pairVal + {10'h000, immK[5:0]};

  // Multiplier: a ninth bit carries the sign of signed operands
  assign mulA = {aVal[7] & (opCode inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD}), aVal};
  assign mulB = {bVal[7] & (opCode inside {OP_SPROD, OP_FSPROD}), bVal};
  assign product = 18'($signed(mulA) * $signed(mulB));
  assign isFrac = opCode inside {OP_FUPROD, OP_FSPROD, OP_FMPROD};
  assign mulRes = isFrac ? {product[14:0], 1'b0} : product[15:0];

  // Flow targets; the pointer is the top register pair
  assign relTarget = s_q.pc + {{4{relOffset[11]}}, relOffset} + 16'h0001;
  assign ptrTarget = {s_q.gpr[IDX_PTR_HI], s_q.gpr[IDX_PTR_LO]};

  // Skip conditions for the three skip forms
  always_comb begin
    unique case (opCode)
      OP_SKIP_EQ:  skipTaken = (aVal == bVal);
      OP_SKIP_CLR: skipTaken = !bVal[bitSel];
      OP_SKIP_SET: skipTaken = bVal[bitSel];
      default:     skipTaken = 1'b0;
    endcase
  end

  // Next state. All effects land at the edge that takes the instruction;
  // the remaining cycles only hold off the next one, which writes both
  // registers of a word or product pair on one edge at the cost of early visibility.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdData = 8'h00;
    cyc = CYC_ONE;
    nextPc = s_q.pc + 16'h0001;
    // Read data appear one cycle after the strobe; unmapped reads give zero
    if (regRd) begin
      if (!regAddr[5]) begin
        s_d.rdData = s_q.gpr[regAddr[4:0]];
      end else if (regAddr == ADDR_FLAGS) begin
        s_d.rdData = s_q.flags;
      end else if (regAddr == ADDR_PC_LO) begin
        s_d.rdData = s_q.pc[7:0];
      end else if (regAddr == ADDR_PC_HI) begin
        s_d.rdData = s_q.pc[15:8];
      end else if (regAddr == ADDR_STACK_LVL) begin
        s_d.rdData = {5'h00, s_q.sp};
      end
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (accept) begin
          unique case (opCode)
            OP_WORD_SUM, OP_WORD_DIFF: begin
              s_d.gpr[dstSel] = wordRes[7:0];
              s_d.gpr[dstHi] = wordRes[15:8];
              s_d.flags[FLAG_Z] = (wordRes == 16'h0000);
              s_d.flags[FLAG_N] = wordRes[15];
              if (opCode == OP_WORD_SUM) begin
                s_d.flags[FLAG_V] = ~pairVal[15] & wordRes[15];
                s_d.flags[FLAG_C] = pairVal[15] & ~wordRes[15];
              end else begin
                s_d.flags[FLAG_V] = pairVal[15] & ~wordRes[15];
                s_d.flags[FLAG_C] = ~pairVal[15] & wordRes[15];
              end
              s_d.flags[FLAG_S] = s_d.flags[FLAG_N] ^ s_d.flags[FLAG_V];
              cyc = CYC_WORD;
            end
            OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD: begin
              s_d.gpr[IDX_PROD_LO] = mulRes[7:0];
              s_d.gpr[IDX_PROD_HI] = mulRes[15:8];
              s_d.flags[FLAG_C] = product[15];
              s_d.flags[FLAG_Z] = (mulRes == 16'h0000);
              cyc = CYC_MUL;
            end
            OP_REL_JUMP: begin
              nextPc = relTarget;
              cyc = CYC_REL_JUMP;
            end
            OP_PTR_JUMP: begin
              nextPc = ptrTarget;
              cyc = CYC_PTR_JUMP;
            end
            OP_DIR_JUMP: begin
              nextPc = jumpTarget;
              cyc = CYC_DIR_JUMP;
            end
            OP_REL_ENTRY, OP_PTR_ENTRY: begin
              s_d.stack[s_q.sp] = s_q.pc + 16'h0001;
              s_d.sp = s_q.sp + 3'h1;
              nextPc = (opCode == OP_REL_ENTRY) ? relTarget : ptrTarget;
              cyc = (opCode == OP_REL_ENTRY) ? CYC_REL_ENTRY : CYC_PTR_ENTRY;
            end
            OP_DIR_ENTRY: begin
              s_d.stack[s_q.sp] = s_q.pc + 16'h0002;
              s_d.sp = s_q.sp + 3'h1;
              nextPc = jumpTarget;
              cyc = CYC_DIR_ENTRY;
            end
            OP_SUB_EXIT, OP_INT_EXIT: begin
              s_d.sp = s_q.sp - 3'h1;
              nextPc = s_q.stack[s_d.sp];
              if (opCode == OP_INT_EXIT) begin
                s_d.flags[FLAG_I] = 1'b1;
              end
              cyc = CYC_EXIT;
            end
            OP_SKIP_EQ, OP_SKIP_CLR, OP_SKIP_SET: begin
              if (skipTaken) begin
                nextPc = s_q.pc + (nextTwoWord ? 16'h0003 : 16'h0002);
                cyc = nextTwoWord ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
              end
            end
            default: begin
              if (aluWr) begin
                s_d.gpr[dstSel] = aluRes;
              end
              s_d.flags = aluFlags;
            end
          endcase
          s_d.pc = nextPc;
          if (cyc == CYC_ONE) begin
            s_d.done = 1'b1;
          end else begin
            s_d.st = ST_HOLD;
            s_d.left = 2'(cyc - 3'h1);
          end
        end
      end
      ST_HOLD: begin
        s_d.left = s_q.left - 2'h1;
        if (s_q.left == 2'h1) begin
          s_d.st = ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Software writes land after the instruction and so win a collision
    if (regWr) begin
      if (!regAddr[5]) begin
        s_d.gpr[regAddr[4:0]] = regWdata;
      end else if (regAddr == ADDR_FLAGS) begin
        s_d.flags = regWdata;
      end else if (regAddr == ADDR_PC_LO) begin
        s_d.pc[7:0] = regWdata;
      end else if (regAddr == ADDR_PC_HI) begin
        s_d.pc[15:8] = regWdata;
      end
    end
  end

  // State register; a low clock enable freezes everything
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= RST_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Checks on the executed results and their timing
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic [7:0]  flagsQ;
  logic [2:0]  spQ;
  assign flagsQ = s_q.flags;
  assign spQ = s_q.sp;

  AST_ADD_SUM: assert property (
    accept && !regWr && opCode == OP_ADD |=>
      s_q.gpr[$past(dstSel)] == 8'($past(aVal) + $past(bVal)))
    else $error("register sum not written");

  AST_SUB_BORROW_FLAG: assert property (
    accept && !regWr && opCode == OP_SUB |=>
      flagsQ[FLAG_C] == ($past(bVal) > $past(aVal)))
    else $error("subtract carry flag wrong");

  AST_INC_KEEPS_C: assert property (
    accept && !regWr && opCode == OP_INC |=>
      flagsQ[FLAG_C] == $past(flagsQ[FLAG_C]) &&
      flagsQ[FLAG_V] == ($past(aVal) == 8'h7f) &&
      s_q.gpr[$past(dstSel)] == 8'($past(aVal) + 8'h01))
    else $error("increment disturbed carry or value");

  AST_LOGIC_V_CLEAR: assert property (
    accept && !regWr && opCode inside {OP_AND, OP_OR, OP_XOR} |=>
      !flagsQ[FLAG_V] && flagsQ[FLAG_C] == $past(flagsQ[FLAG_C]))
    else $error("logic op flags wrong");

  AST_MUL_TWO_CYCLES: assert property (
    accept && opCode == OP_UPROD |=>
      !opReady ##1 (opReady || !$past(ce)))
    else $error("multiply did not take two cycles");

  AST_DIR_JUMP: assert property (
    accept && !regWr && opCode == OP_DIR_JUMP |=>
      pc == $past(jumpTarget) && !opReady ##1 !opReady)
    else $error("direct jump target or length wrong");

  AST_CALL_PUSH: assert property (
    accept && !regWr && opCode == OP_REL_ENTRY |=>
      spQ == 3'($past(spQ) + 3'h1) && pc == $past(relTarget))
    else $error("relative call did not push and jump");

  AST_SKIP_EQ: assert property (
    accept && !regWr && opCode == OP_SKIP_EQ && aVal == bVal && !nextTwoWord |=>
      pc == 16'($past(pc) + 16'h0002))
    else $error("equal skip advanced wrongly");

  AST_SKIP_FLAGS: assert property (
    accept && !regWr && opCode inside {OP_SKIP_CLR, OP_SKIP_SET} |=>
      flagsQ == $past(flagsQ))
    else $error("bit skip changed flags");

  AST_FILL_ONES: assert property (
    accept && !regWr && opCode == OP_FILL_ONES |=>
      s_q.gpr[$past(dstSel)] == 8'hff && flagsQ == $past(flagsQ))
    else $error("fill ones wrong");

  AST_INT_EXIT: assert property (
    accept && !regWr && opCode == OP_INT_EXIT |=>
      flagsQ[FLAG_I] && !opReady [*3])
    else $error("interrupt exit wrong");

endmodule : afx_execute

//--- pkg/afx_pkg.sv
// Shared constants and types of the ALU and flow execute block
// Function
// - Add registers, optional carry, five flags, one cycle
// - Subtract registers, optional borrow, five flags, one cycle
// - Subtract immediate, optional borrow, five flags, one cycle
// - Word pair plus or minus immediate, two cycles
// - And, or, exclusive or; Z N V; one cycle
// - Set or clear masked bits, Z N V
// - Increment or decrement, carry left unchanged
// - Test register by self conjunction, Z N V
// - Multiply three signedness forms into pair 1:0
// - Fractional multiplies shift product left one bit
// - Relative, pointer jump two cycles; direct three
// - Calls push return address; three or four cycles
// - Compare forms update five flags, discard result
// - Skip next instruction when two registers equal
// - Skip on chosen register bit clear or set
package afx_pkg;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC    = 16'h0000;

  // Cycles per instruction
  localparam logic [2:0] CYC_ONE        = 3'h1;
  localparam logic [2:0] CYC_WORD       = 3'h2;
  localparam logic [2:0] CYC_MUL        = 3'h2;
  localparam logic [2:0] CYC_REL_JUMP   = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP   = 3'h2;
  localparam logic [2:0] CYC_DIR_JUMP   = 3'h3;
  localparam logic [2:0] CYC_REL_ENTRY  = 3'h3;
  localparam logic [2:0] CYC_PTR_ENTRY  = 3'h3;
  localparam logic [2:0] CYC_DIR_ENTRY  = 3'h4;
  localparam logic [2:0] CYC_EXIT       = 3'h4;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG  = 3'h3;

  // Register port offsets; 6'h00..6'h1f are the working registers
  localparam logic [5:0] ADDR_FLAGS     = 6'h20;
  localparam logic [5:0] ADDR_PC_LO     = 6'h21;
  localparam logic [5:0] ADDR_PC_HI     = 6'h22;
  localparam logic [5:0] ADDR_STACK_LVL = 6'h23;

  // Fixed register indices
  localparam logic [4:0] IDX_PROD_LO = 5'h00;
  localparam logic [4:0] IDX_PROD_HI = 5'h01;
  localparam logic [4:0] IDX_PTR_LO  = 5'h1e;
  localparam logic [4:0] IDX_PTR_HI  = 5'h1f;

  typedef enum logic [5:0] {
    OP_NONE, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_BORROW,
    OP_SUB_IMM_BORROW, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
    OP_INVERT, OP_MINUS, OP_SET_BITS, OP_CLEAR_BITS, OP_INC, OP_DEC,
    OP_TEST, OP_ZERO_REG, OP_FILL_ONES, OP_CMP, OP_CMP_BORROW, OP_CMP_IMM,
    OP_WORD_SUM, OP_WORD_DIFF, OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD,
    OP_FSPROD, OP_FMPROD, OP_REL_JUMP, OP_PTR_JUMP, OP_DIR_JUMP,
    OP_REL_ENTRY, OP_PTR_ENTRY, OP_DIR_ENTRY, OP_SUB_EXIT, OP_INT_EXIT,
    OP_SKIP_EQ, OP_SKIP_CLR, OP_SKIP_SET
  } afx_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } afx_state_e;

endpackage : afx_pkg

//--- core/afx_alu.sv
// Single-cycle 8-bit arithmetic and logic unit with flag update
`timescale 1ns/100ps
module afx_alu (
  input  wire afx_pkg::afx_op_e op,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  input  wire logic [7:0]       flagsIn,
  output logic      [7:0]       res,
  output logic      [7:0]       flagsOut,
  output logic                  wrRes
);
  import afx_pkg::*;

  logic [7:0] x;
  logic [7:0] y;
  logic       cin;
  logic [8:0] sum;
  logic [8:0] dif;
  logic       c;
  logic       h;
  logic       v;
  logic       updZnv;
  logic       updC;
  logic       updH;
  logic       sticky;

  // Operand shaping: negation is 0 - a, step ops use a constant one
  always_comb begin
    x = (op == OP_MINUS) ? 8'h00 : a;
    y = (op == OP_MINUS) ? a : ((op == OP_INC || op == OP_DEC) ? 8'h01 : b);
    sticky = (op == OP_SUB_BORROW || op == OP_SUB_IMM_BORROW || op == OP_CMP_BORROW);
    cin = (sticky || op == OP_ADD_CARRY) ? flagsIn[FLAG_C] : 1'b0;
    sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    dif = {1'b0, x} - {1'b0, y} - {8'h00, cin};
  end

  // Result and flag selection per operation class
  always_comb begin
    res = a;
    wrRes = 1'b1;
    c = 1'b0;
    h = 1'b0;
    v = 1'b0;
    updZnv = 1'b1;
    updC = 1'b0;
    updH = 1'b0;
    unique case (op)
      OP_ADD, OP_ADD_CARRY, OP_INC: begin
        res = sum[7:0];
        c = sum[8];
        h = (x[3] & y[3]) | (y[3] & ~res[3]) | (~res[3] & x[3]);
        v = (x[7] & y[7] & ~res[7]) | (~x[7] & ~y[7] & res[7]);
        updC = (op != OP_INC);
        updH = (op != OP_INC);
      end
      OP_SUB, OP_SUB_IMM, OP_SUB_BORROW, OP_SUB_IMM_BORROW, OP_MINUS, OP_DEC,
      OP_CMP, OP_CMP_BORROW, OP_CMP_IMM: begin
        res = dif[7:0];
        c = dif[8];
        h = (~x[3] & y[3]) | (y[3] & res[3]) | (res[3] & ~x[3]);
        v = (x[7] & ~y[7] & ~res[7]) | (~x[7] & y[7] & res[7]);
        updC = (op != OP_DEC);
        updH = (op != OP_DEC);
        wrRes = !(op == OP_CMP || op == OP_CMP_BORROW || op == OP_CMP_IMM);
      end
      OP_AND, OP_AND_IMM, OP_TEST: res = a & b;
      OP_OR, OP_OR_IMM, OP_SET_BITS: res = a | b;
      OP_XOR, OP_ZERO_REG: res = a ^ b;
      OP_CLEAR_BITS: res = a & ~b;
      OP_INVERT: begin
        res = ~a;
        c = 1'b1;
        updC = 1'b1;
      end
      OP_FILL_ONES: begin
        res = 8'hff;
        updZnv = 1'b0;
      end
      default: begin
        wrRes = 1'b0;
        updZnv = 1'b0;
      end
    endcase
  end

  // Flag merge; borrow forms keep Z only while the result stays zero
  always_comb begin
    flagsOut = flagsIn;
    if (updZnv) begin
      flagsOut[FLAG_Z] = (res == 8'h00) & (!sticky | flagsIn[FLAG_Z]);
      flagsOut[FLAG_N] = res[7];
      flagsOut[FLAG_V] = v;
      flagsOut[FLAG_S] = res[7] ^ v;
    end
    if (updC) begin
      flagsOut[FLAG_C] = c;
    end
    if (updH) begin
      flagsOut[FLAG_H] = h;
    end
  end

endmodule : afx_alu

//--- verification/alu_and_flow_execute_test.sv
// Self-checking bench for the ALU and program flow execute block
`timescale 1ns/100ps
module alu_and_flow_execute_test;
  import afx_pkg::*;

  typedef struct {
    afx_op_e     o;
    logic [7:0]  a, b, k, fin;
    logic [15:0] e;
    logic [7:0]  f;
    logic [2:0]  c;
  } afx_row_s;
  typedef struct {
    afx_op_e     o;
    logic [2:0]  c;
    logic [11:0] ro;
    logic [15:0] jt;
    logic [2:0]  bs;
    logic        tw;
    logic [15:0] p;
  } afx_flow_s;

  logic          clk         = 1'b0;
  logic          resetn      = 1'b0;
  logic          ce          = 1'b1;
  logic          opValid     = 1'b0;
  afx_op_e       opCode      = OP_NONE;
  logic [4:0]    dstSel      = 5'h02;
  logic [4:0]    srcSel      = 5'h03;
  logic [7:0]    immK        = 8'h00;
  logic [2:0]    bitSel      = 3'h0;
  logic [11:0]   relOffset   = 12'h000;
  logic [15:0]   jumpTarget  = 16'h0000;
  logic          nextTwoWord = 1'b0;
  logic [5:0]    regAddr     = 6'h00;
  logic [7:0]    regWdata    = 8'h00;
  logic          regWr       = 1'b0;
  logic          regRd       = 1'b0;
  logic          opReady;
  logic          opDone;
  logic [15:0]   pc;
  logic [7:0]    flags;
  logic [7:0]    regRdata;
  int            numErrors   = 0;
  int            checksDone  = 0;

  // Byte ops use reg2 op reg3; expected value is reg3:reg2, or reg1:reg0 for products
  afx_row_s rows [0:31] = '{
    '{OP_ADD,8'h0f,8'h01,8'h00,8'h00,16'h0110,8'h20,3'h1},
    '{OP_ADD_CARRY,8'hff,8'h00,8'h00,8'h01,16'h0000,8'h23,3'h1},
    '{OP_SUB,8'h80,8'h01,8'h00,8'h00,16'h017f,8'h28,3'h1},
    '{OP_SUB_BORROW,8'h05,8'h05,8'h00,8'h03,16'h05ff,8'h25,3'h1},
    '{OP_SUB_IMM,8'h10,8'h00,8'h20,8'h00,16'h00f0,8'h05,3'h1},
    '{OP_SUB_IMM_BORROW,8'h05,8'h00,8'h04,8'h03,16'h0000,8'h02,3'h1},
    '{OP_AND,8'hf0,8'h3c,8'h00,8'h01,16'h3c30,8'h01,3'h1},
    '{OP_AND_IMM,8'h0f,8'h00,8'hf0,8'h00,16'h0000,8'h02,3'h1},
    '{OP_OR,8'h80,8'h01,8'h00,8'h08,16'h0181,8'h04,3'h1},
    '{OP_OR_IMM,8'h00,8'h00,8'h00,8'h00,16'h0000,8'h02,3'h1},
    '{OP_XOR,8'haa,8'haa,8'h00,8'h00,16'haa00,8'h02,3'h1},
    '{OP_SET_BITS,8'h01,8'h00,8'h80,8'h00,16'h0081,8'h04,3'h1},
    '{OP_CLEAR_BITS,8'hff,8'h00,8'h0f,8'h01,16'h00f0,8'h05,3'h1},
    '{OP_INC,8'h7f,8'h00,8'h00,8'h01,16'h0080,8'h0d,3'h1},
    '{OP_DEC,8'h80,8'h00,8'h00,8'h00,16'h007f,8'h08,3'h1},
    '{OP_TEST,8'h00,8'h00,8'h00,8'h08,16'h0000,8'h02,3'h1},
    '{OP_INVERT,8'h55,8'h00,8'h00,8'h00,16'h00aa,8'h05,3'h1},
    '{OP_MINUS,8'h80,8'h00,8'h00,8'h00,16'h0080,8'h0d,3'h1},
    '{OP_ZERO_REG,8'h5a,8'h00,8'h00,8'h0c,16'h0000,8'h02,3'h1},
    '{OP_FILL_ONES,8'h00,8'h00,8'h00,8'h2b,16'h00ff,8'h2b,3'h1},
    '{OP_CMP,8'h10,8'h10,8'h00,8'h00,16'h1010,8'h02,3'h1},
    '{OP_CMP_BORROW,8'h10,8'h10,8'h00,8'h01,16'h1010,8'h25,3'h1},
    '{OP_CMP_IMM,8'h20,8'h00,8'h30,8'h00,16'h0020,8'h05,3'h1},
    '{OP_WORD_SUM,8'hff,8'h7f,8'h01,8'h00,16'h8000,8'h0c,3'h2},
    '{OP_WORD_SUM,8'hff,8'hff,8'h3f,8'h00,16'h003e,8'h01,3'h2},
    '{OP_WORD_DIFF,8'h00,8'h00,8'h01,8'h00,16'hffff,8'h15,3'h2},
    '{OP_UPROD,8'hff,8'hff,8'h00,8'h00,16'hfe01,8'h01,3'h2},
    '{OP_SPROD,8'hff,8'h02,8'h00,8'h00,16'hfffe,8'h01,3'h2},
    '{OP_MPROD,8'h02,8'hff,8'h00,8'h00,16'h01fe,8'h00,3'h2},
    '{OP_FUPROD,8'h80,8'h80,8'h00,8'h00,16'h8000,8'h00,3'h2},
    '{OP_FSPROD,8'hc0,8'h40,8'h00,8'h00,16'he000,8'h01,3'h2},
    '{OP_FMPROD,8'hc0,8'h80,8'h00,8'h00,16'hc000,8'h01,3'h2}
  };

  // Flow sequence; each expected counter follows from the row before it
  afx_flow_s flow [0:14] = '{
    '{OP_REL_JUMP,3'h2,12'hffe,16'h0000,3'h0,1'b0,16'h00ff},
    '{OP_PTR_JUMP,3'h2,12'h000,16'h0000,3'h0,1'b0,16'h1234},
    '{OP_DIR_JUMP,3'h3,12'h000,16'habcd,3'h0,1'b0,16'habcd},
    '{OP_DIR_ENTRY,3'h4,12'h000,16'h2000,3'h0,1'b0,16'h2000},
    '{OP_REL_ENTRY,3'h3,12'h010,16'h0000,3'h0,1'b0,16'h2011},
    '{OP_PTR_ENTRY,3'h3,12'h000,16'h0000,3'h0,1'b0,16'h1234},
    '{OP_SUB_EXIT,3'h4,12'h000,16'h0000,3'h0,1'b0,16'h2012},
    '{OP_INT_EXIT,3'h4,12'h000,16'h0000,3'h0,1'b0,16'h2001},
    '{OP_SUB_EXIT,3'h4,12'h000,16'h0000,3'h0,1'b0,16'habcf},
    '{OP_SKIP_EQ,3'h2,12'h000,16'h0000,3'h0,1'b0,16'habd1},
    '{OP_SKIP_EQ,3'h3,12'h000,16'h0000,3'h0,1'b1,16'habd4},
    '{OP_SKIP_CLR,3'h3,12'h000,16'h0000,3'h0,1'b1,16'habd7},
    '{OP_SKIP_CLR,3'h1,12'h000,16'h0000,3'h1,1'b0,16'habd8},
    '{OP_SKIP_SET,3'h2,12'h000,16'h0000,3'h1,1'b0,16'habda},
    '{OP_SKIP_SET,3'h1,12'h000,16'h0000,3'h0,1'b0,16'habdb}
  };

  afx_execute afx_execute_i (
    .clk(clk), .resetn(resetn), .ce(ce), .opValid(opValid), .opCode(opCode),
    .dstSel(dstSel), .srcSel(srcSel), .immK(immK), .bitSel(bitSel),
    .relOffset(relOffset), .jumpTarget(jumpTarget), .nextTwoWord(nextTwoWord),
    .opReady(opReady), .opDone(opDone), .pc(pc), .flags(flags),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata)
  );

  // 125 MHz core clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Every comparison funnels through here so the counts stay consistent
  task automatic check16(string w, logic [15:0] exp, logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", w, exp, got);
    end
  endtask : check16

  // One-cycle write strobe; the port never stalls
  task automatic regWrite(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : regWrite

  // Read data stands only in the cycle after the strobe, so sample there
  task automatic regCheck(logic [5:0] a, logic [7:0] e, string w);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    check16(w, {8'h00, e}, {8'h00, regRdata});
  endtask : regCheck

  // Offer one instruction for a single edge and count cycles up to the done pulse
  task automatic issue(afx_op_e o, logic [2:0] c, logic [7:0] k = 8'h00,
                       logic [11:0] ro = 12'h000, logic [15:0] jt = 16'h0000,
                       logic [2:0] bs = 3'h0, logic tw = 1'b0);
    int n;
    @(posedge clk);
    opValid     <= 1'b1;
    opCode      <= o;
    immK        <= k;
    relOffset   <= ro;
    jumpTarget  <= jt;
    bitSel      <= bs;
    nextTwoWord <= tw;
    @(posedge clk);
    opValid     <= 1'b0;
    n = 1;
    #1;
    while (opDone !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check16("cycles", {13'h0000, c}, 16'(n));
  endtask : issue

  task automatic finish_test();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    afx_row_s    r;
    afx_flow_s   g;
    logic [15:0] p;
    logic [4:0]  chk;
    logic [7:0]  fm;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check16("reset pc", RST_PC, pc);
    check16("reset flags", {8'h00, RST_FLAGS}, {8'h00, flags});
    check16("reset ready done", 16'h0002, {14'h0000, opReady, opDone});
    regCheck(ADDR_STACK_LVL, 8'h00, "reset level");
    regCheck(6'h05, 8'h00, "reset reg");
    // S is left out for byte ops: only the word forms promise it
    foreach (rows[i]) begin
      r = rows[i];
      chk = (r.o >= OP_UPROD && r.o <= OP_FMPROD) ? IDX_PROD_LO : 5'h02;
      fm = (r.o == OP_WORD_SUM || r.o == OP_WORD_DIFF) ? 8'hff : 8'hef;
      regWrite(6'h02, r.a);
      regWrite(6'h03, r.b);
      regWrite(ADDR_FLAGS, r.fin);
      p = pc;
      issue(r.o, r.c, r.k);
      check16("pc step", p + 16'h0001, pc);
      regCheck({1'b0, chk}, r.e[7:0], "low byte");
      regCheck({1'b0, chk} + 6'h01, r.e[15:8], "high byte");
      check16("flags", {8'h00, r.f & fm}, {8'h00, flags & fm});
    end
    // Equal pair for skips, pointer pair, start counter and flags with I clear
    regWrite(6'h02, 8'h5a);
    regWrite(6'h03, 8'h5a);
    regWrite(6'h1e, 8'h34);
    regWrite(6'h1f, 8'h12);
    regWrite(ADDR_PC_LO, 8'h00);
    regWrite(ADDR_PC_HI, 8'h01);
    regWrite(ADDR_FLAGS, 8'h3f);
    foreach (flow[i]) begin
      g = flow[i];
      issue(g.o, g.c, 8'h00, g.ro, g.jt, g.bs, g.tw);
      check16("pc", g.p, pc);
    end
    check16("flow flags", 16'h00bf, {8'h00, flags});
    // Two increments offered on consecutive edges are both taken
    @(posedge clk);
    opValid <= 1'b1;
    opCode  <= OP_INC;
    repeat (2) @(posedge clk);
    opValid <= 1'b0;
    regCheck(6'h02, 8'h5c, "back to back");
    // An offer in the multiply's stall cycle must be ignored
    @(posedge clk);
    opValid <= 1'b1;
    opCode  <= OP_UPROD;
    @(posedge clk);
    opCode  <= OP_INC;
    @(posedge clk);
    opValid <= 1'b0;
    regCheck(6'h02, 8'h5c, "refused in stall");
    regCheck(6'h00, 8'h58, "product low");
    regCheck(6'h01, 8'h20, "product high");
    // Clock enable low freezes the block
    @(posedge clk);
    ce      <= 1'b0;
    opValid <= 1'b1;
    repeat (2) @(posedge clk);
    ce      <= 1'b1;
    opValid <= 1'b0;
    regCheck(6'h02, 8'h5c, "frozen");
    // Unmapped read and read-only level; pops have emptied the stack
    regCheck(6'h30, 8'h00, "unmapped");
    regWrite(ADDR_STACK_LVL, 8'h05);
    regCheck(ADDR_STACK_LVL, 8'h00, "level");
    // Counter and status through the port: two increments and a product since abdb
    regCheck(ADDR_PC_LO, 8'hde, "pc low read");
    regCheck(ADDR_PC_HI, 8'hab, "pc high read");
    regCheck(ADDR_FLAGS, 8'ha0, "flags read");
    // A reset in mid-run clears counter, flags and working registers again
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check16("mid reset pc", RST_PC, pc);
    check16("mid reset flags", {8'h00, RST_FLAGS}, {8'h00, flags});
    regCheck(6'h02, 8'h00, "mid reset reg");
    finish_test();
  end

  // The run needs about five hundred cycles; twenty thousand means a hang
  initial begin
    #(8 * 20000);
    numErrors++;
    finish_test();
  end

endmodule : alu_and_flow_execute_test
